// ---- hsg_defs.svh ----
// haptic signal generator: register offsets, field positions, reset values
// and timing counts; included by the package and the design module
`ifndef HSG_DEFS_SVH
`define HSG_DEFS_SVH

`define HSG_ADDR_W 8
`define HSG_OFF_CTRL 8'h90
`define HSG_OFF_DIV 8'h91
`define HSG_OFF_L1 8'h92
`define HSG_OFF_D1 8'h93
`define HSG_OFF_L2 8'h94
`define HSG_OFF_D2 8'h95
`define HSG_OFF_L3 8'h96
`define HSG_OFF_D3 8'h97
`define HSG_OFF_STS 8'h98
`define HSG_OFF_MIX 8'h99

`define HSG_RATE_MSB 14
`define HSG_RATE_LSB 11
`define HSG_TRIG_BIT 4
`define HSG_MODE_MSB 3
`define HSG_MODE_LSB 2
`define HSG_ACT_BIT 1
`define HSG_ACTIVE_BIT 0

`define HSG_DIV_RST 15'h7FFF
`define HSG_MIX_RST 8'h00
`define HSG_SRC_HAPTIC 8'h06
`define HSG_RATE_ASYNC 4'h8

// clock and step timing
`define HSG_CLK_HZ 10000000
`define HSG_STEP_NS 625000
`define HSG_CLK_NS 100
`define HSG_TICK_SYNC_HZ 6144000
`define HSG_TICK_ASYNC_HZ 5644800

`endif

// ---- hsg_pkg.sv ----
// haptic signal generator types: modes, states and the bus request struct
// assumes hsg_defs.svh is on the include path
`include "hsg_defs.svh"

package hsg_pkg;

  typedef enum logic [1:0] {
    HSG_MODE_OFF = 2'h0,
    HSG_MODE_CONT = 2'h1,
    HSG_MODE_SHOT = 2'h2,
    HSG_MODE_RSVD = 2'h3
  } hsg_mode_t;

  // gray order along idle -> p1 -> p2 -> p3
  typedef enum logic [1:0] {
    HSG_ST_IDLE = 2'b00,
    HSG_ST_P1 = 2'b01,
    HSG_ST_P2 = 2'b11,
    HSG_ST_P3 = 2'b10
  } hsg_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [`HSG_ADDR_W-1:0] addr;
    logic [15:0] wdata;
  } hsg_req_t;

endpackage

// ---- hsg_generator.sv ----
// haptic signal generator: register file, one-shot sequencer, tone/dc source
// assumes a 10 MHz clock, a single-cycle strobe bus and an external mixer
// that consumes the 16-bit sample when sample_valid_o pulses
`timescale 1ns/1ns
`include "hsg_defs.svh"

// Overview of operation
// - mixer source code 06h selects haptic stream
// - mode 00 off, 01 continuous, 10 one-shot
// - trigger write runs phases one, two, three
// - actuator bit: 0 rotating mass, 1 resonant
// - rotating mass outputs signed DC level
// - resonant outputs square wave, negative inverts
// - continuous mode uses only phase two level
// - tone freq is tick over 2(div+1)
// - tick is 6.144 or 5.6448 MHz
// - rate below 1000 uses 6.144 MHz tick
// - divider ignored for rotating mass
// - phase levels are 8-bit two's complement
// - phases one and three use own levels
// - phase one lasts count times 0.625 ms
// - phase two lasts 11-bit count steps
// - phase three lasts 9-bit count steps
// - status bit high while one-shot runs
// - rate codes 0-2 sync, 8-9 async
module hsg_generator
  import hsg_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire hsg_req_t bus_i,
  output logic [15:0] rdata_o,
  output logic [15:0] sample_o,
  output logic sample_valid_o,
  output logic [15:0] mixer_data_o
);

  localparam int STEP_CYC = `HSG_STEP_NS / `HSG_CLK_NS;
  // tick enable: phase accumulator at 10 MHz produces the tick rate
  localparam logic [23:0] TICK_INC_SYNC =
    24'((64'(`HSG_TICK_SYNC_HZ) << 24) / `HSG_CLK_HZ);
  localparam logic [23:0] TICK_INC_ASYNC =
    24'((64'(`HSG_TICK_ASYNC_HZ) << 24) / `HSG_CLK_HZ);

  function automatic logic sel(input logic [`HSG_ADDR_W-1:0] a,
                               input logic [`HSG_ADDR_W-1:0] off);
    sel = (a == off);
  endfunction

  logic [3:0] rate_reg;
  hsg_mode_t mode_reg;
  logic act_reg;
  logic [14:0] div_reg;
  logic [7:0] l1_reg, l2_reg, l3_reg;
  logic [8:0] d1_reg, d3_reg;
  logic [10:0] d2_reg;
  logic [7:0] mix_src_reg;
  logic [15:0] rdata_reg;
  hsg_state_t st_reg, st_next;
  logic [12:0] step_cnt_reg;
  logic [10:0] phase_cnt_reg;
  logic [23:0] tick_acc_reg;
  logic tick_reg;
  logic [14:0] div_cnt_reg;
  logic pol_reg;
  logic [15:0] sample_reg;
  logic trig;
  logic step_done;
  logic phase_end;
  logic [10:0] phase_len;
  logic [7:0] level;
  logic [23:0] tick_sum;
  logic tick_async;

  assign trig = bus_i.wr && sel(bus_i.addr, `HSG_OFF_CTRL) &&
    bus_i.wdata[`HSG_TRIG_BIT] && mode_reg == HSG_MODE_SHOT;

  // write strobe aimed at one offset
  function automatic logic wr_sel(input hsg_req_t r,
                                  input logic [`HSG_ADDR_W-1:0] off);
    wr_sel = r.wr && sel(r.addr, off);
  endfunction

  // 8-bit level placed at the top of the 16-bit sample word
  function automatic logic [15:0] scale(input logic [7:0] lvl);
    scale = {lvl, 8'h00};
  endfunction

  // control fields; the trigger bit is a strobe and is never stored
  // a reserved mode code is kept but drives no output
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rate_reg <= 4'h0;
      mode_reg <= HSG_MODE_OFF;
      act_reg <= 1'b0;
    end else if (wr_sel(bus_i, `HSG_OFF_CTRL)) begin
      rate_reg <= bus_i.wdata[`HSG_RATE_MSB:`HSG_RATE_LSB];
      mode_reg <= hsg_mode_t'(bus_i.wdata[`HSG_MODE_MSB:`HSG_MODE_LSB]);
      act_reg <= bus_i.wdata[`HSG_ACT_BIT];
    end
  end

  // resonance divider, read only by the resonant path
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_reg <= `HSG_DIV_RST;
    end else if (wr_sel(bus_i, `HSG_OFF_DIV)) begin
      div_reg <= bus_i.wdata[14:0];
    end
  end

  // phase levels, signed 8-bit
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      l1_reg <= 8'h00;
    end else if (wr_sel(bus_i, `HSG_OFF_L1)) begin
      l1_reg <= bus_i.wdata[7:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      l2_reg <= 8'h00;
    end else if (wr_sel(bus_i, `HSG_OFF_L2)) begin
      l2_reg <= bus_i.wdata[7:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      l3_reg <= 8'h00;
    end else if (wr_sel(bus_i, `HSG_OFF_L3)) begin
      l3_reg <= bus_i.wdata[7:0];
    end
  end

  // phase lengths in 0.625 ms steps
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      d1_reg <= 9'h000;
    end else if (wr_sel(bus_i, `HSG_OFF_D1)) begin
      d1_reg <= bus_i.wdata[8:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      d2_reg <= 11'h000;
    end else if (wr_sel(bus_i, `HSG_OFF_D2)) begin
      d2_reg <= bus_i.wdata[10:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      d3_reg <= 9'h000;
    end else if (wr_sel(bus_i, `HSG_OFF_D3)) begin
      d3_reg <= bus_i.wdata[8:0];
    end
  end

  // output mixer source select
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mix_src_reg <= `HSG_MIX_RST;
    end else if (wr_sel(bus_i, `HSG_OFF_MIX)) begin
      mix_src_reg <= bus_i.wdata[7:0];
    end
  end

  // a one-shot profile is in progress
  logic busy;
  assign busy = st_reg != HSG_ST_IDLE;

  // register image for a read; unmapped offsets and the trigger read 0
  function automatic logic [15:0] read_word(
      input logic [`HSG_ADDR_W-1:0] a);
    logic [15:0] w;
    w = 16'h0000;
    case (a)
      `HSG_OFF_CTRL: begin
        w[`HSG_RATE_MSB:`HSG_RATE_LSB] = rate_reg;
        w[`HSG_MODE_MSB:`HSG_MODE_LSB] = mode_reg;
        w[`HSG_ACT_BIT] = act_reg;
      end
      `HSG_OFF_DIV: w[14:0] = div_reg;
      `HSG_OFF_L1: w[7:0] = l1_reg;
      `HSG_OFF_D1: w[8:0] = d1_reg;
      `HSG_OFF_L2: w[7:0] = l2_reg;
      `HSG_OFF_D2: w[10:0] = d2_reg;
      `HSG_OFF_L3: w[7:0] = l3_reg;
      `HSG_OFF_D3: w[8:0] = d3_reg;
      `HSG_OFF_STS: w[`HSG_ACTIVE_BIT] = busy;
      `HSG_OFF_MIX: w[7:0] = mix_src_reg;
      default: w = 16'h0000;
    endcase
    read_word = w;
  endfunction

  // read data, valid only in the cycle after the read strobe
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_reg <= 16'h0000;
    end else if (bus_i.rd) begin
      rdata_reg <= read_word(bus_i.addr);
    end else begin
      rdata_reg <= 16'h0000;
    end
  end
  assign rdata_o = rdata_reg;

  // 0.625 ms step counter, restarted on trigger
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      step_cnt_reg <= 13'h0000;
    end else if (trig || st_reg == HSG_ST_IDLE || step_done) begin
      step_cnt_reg <= 13'h0000;
    end else begin
      step_cnt_reg <= step_cnt_reg + 13'h0001;
    end
  end
  assign step_done = step_cnt_reg == 13'(STEP_CYC - 1);

  always_comb begin
    case (st_reg)
      HSG_ST_P1: begin
        phase_len = {2'b00, d1_reg};
      end
      HSG_ST_P2: begin
        phase_len = d2_reg;
      end
      HSG_ST_P3: begin
        phase_len = {2'b00, d3_reg};
      end
      default: phase_len = 11'h000;
    endcase
  end
  // zero-length phase ends at once; otherwise after phase_len steps
  assign phase_end = phase_len == 11'h000 ||
    (step_done && phase_cnt_reg == phase_len - 11'h001);

  always_comb begin
    st_next = st_reg;
    case (st_reg)
      HSG_ST_IDLE: begin
        if (trig) st_next = HSG_ST_P1;
      end
      HSG_ST_P1: begin
        if (phase_end) st_next = HSG_ST_P2;
      end
      HSG_ST_P2: begin
        if (phase_end) st_next = HSG_ST_P3;
      end
      HSG_ST_P3: begin
        if (phase_end) st_next = HSG_ST_IDLE;
      end
      default: st_next = HSG_ST_IDLE;
    endcase
    // leaving one-shot mode aborts; a new trigger restarts phase one
    if (mode_reg != HSG_MODE_SHOT) begin
      st_next = HSG_ST_IDLE;
    end else if (trig) begin
      st_next = HSG_ST_P1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= HSG_ST_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // steps spent in the current phase, cleared on every state change
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_cnt_reg <= 11'h000;
    end else if (st_next != st_reg || trig) begin
      phase_cnt_reg <= 11'h000;
    end else if (step_done) begin
      phase_cnt_reg <= phase_cnt_reg + 11'h001;
    end
  end

  // system tick enable, rate chosen by the rate field
  // the average rate sits slightly below nominal (truncated increment); single ticks jitter by one clock
  assign tick_async = rate_reg >= `HSG_RATE_ASYNC;
  assign tick_sum = tick_acc_reg +
    (tick_async ? TICK_INC_ASYNC : TICK_INC_SYNC);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_acc_reg <= 24'h000000;
    end else begin
      tick_acc_reg <= tick_sum;
    end
  end

  // a carry out of the accumulator marks one tick
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= tick_sum < tick_acc_reg;
    end
  end

  // end of one half period of the resonant wave
  logic half_done;
  assign half_done = tick_reg && div_cnt_reg >= div_reg;

  // divider count restarts after div+1 ticks
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_cnt_reg <= 15'h0000;
    end else if (half_done) begin
      div_cnt_reg <= 15'h0000;
    end else if (tick_reg) begin
      div_cnt_reg <= div_cnt_reg + 15'h0001;
    end
  end

  // polarity toggles every div+1 ticks: period 2(div+1) ticks
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pol_reg <= 1'b0;
    end else if (half_done) begin
      pol_reg <= ~pol_reg;
    end
  end

  // level of the phase now running; zero when idle or disabled
  always_comb begin
    level = 8'h00;
    case (mode_reg)
      HSG_MODE_CONT: begin
        level = l2_reg;
      end
      HSG_MODE_SHOT: begin
        case (st_reg)
          HSG_ST_P1: begin
            level = l1_reg;
          end
          HSG_ST_P2: begin
            level = l2_reg;
          end
          HSG_ST_P3: begin
            level = l3_reg;
          end
          default: level = 8'h00;
        endcase
      end
      default: level = 8'h00;
    endcase
  end

  // level scaled to 16-bit full scale; resonant output flips sign
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sample_reg <= 16'h0000;
    end else if (!act_reg) begin
      sample_reg <= scale(level);
    end else if (pol_reg) begin
      sample_reg <= 16'(-$signed(scale(level)));
    end else begin
      sample_reg <= scale(level);
    end
  end
  assign sample_o = sample_reg;
  assign sample_valid_o = tick_reg;
  // mixer input stage: haptic sample only when its source code is set
  assign mixer_data_o = (mix_src_reg == `HSG_SRC_HAPTIC) ?
    sample_reg : 16'h0000;

endmodule

// ---- hsg_checker.sv ----
// checker: port-level properties of the haptic generator
// assumes it is bound to hsg_generator from the testbench
`timescale 1ns/1ns
module hsg_checker
  import hsg_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire hsg_req_t bus_i,
  input wire logic [15:0] rdata_o,
  input wire logic [15:0] sample_o,
  input wire logic sample_valid_o,
  input wire logic [15:0] mixer_data_o
);
  logic [15:0] ctl_reg, lvl_reg, mix_reg;
  // shadow of the settings the properties depend on
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctl_reg <= 16'h0;
      lvl_reg <= 16'h0;
      mix_reg <= 16'h0;
    end else if (bus_i.wr) begin
      if (bus_i.addr == 8'h90) ctl_reg <= bus_i.wdata;
      if (bus_i.addr == 8'h94) lvl_reg <= {bus_i.wdata[7:0], 8'h00};
      if (bus_i.addr == 8'h99) mix_reg <= bus_i.wdata;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  chk_rd_idle: assert property (!$past(bus_i.rd) |-> rdata_o == 16'h0)
    else $error("read data outside read slot");
  chk_sts_bits: assert property ($past(bus_i.rd && bus_i.addr == 8'h98)
    |-> rdata_o[15:1] == 15'h0) else $error("status upper bits set");
  chk_tick_gap: assert property (!sample_valid_o |-> ##[1:2] sample_valid_o)
    else $error("tick missing");
  chk_off_quiet: assert property ((ctl_reg[3:2] inside {2'h0, 2'h3})[*4]
    |-> sample_o == 16'h0) else $error("output while disabled");
  chk_dc_level: assert property ((ctl_reg[3:1] == 3'h2 && !bus_i.wr)[*4]
    |-> sample_o == lvl_reg) else $error("dc level wrong");
  chk_ac_level: assert property ((ctl_reg[3:1] == 3'h3 && !bus_i.wr)[*4]
    |-> sample_o == lvl_reg || sample_o == -lvl_reg)
    else $error("ac amplitude wrong");
  chk_mix_on: assert property ((mix_reg[7:0] == 8'h06 && $stable(sample_o))[*3]
    |-> mixer_data_o == sample_o) else $error("mixer lost haptic");
  chk_mix_off: assert property ((mix_reg[7:0] != 8'h06)[*2]
    |-> mixer_data_o == 16'h0) else $error("mixer leaks haptic");
  cover property (sample_valid_o && sample_o[15]);
  cover property ($past(bus_i.rd && bus_i.addr == 8'h98) && rdata_o[0]);
  cover property (mixer_data_o != 16'h0);
endmodule

// ---- hsg_mix_model.sv ----
// partner: output mixer input stage, holds the last haptic sample taken
// assumes the generator pulses valid_i once per tick
`timescale 1ns/1ns
module hsg_mix_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic valid_i,
  input wire logic [15:0] data_i,
  output logic [15:0] last_o
);
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) last_o <= 16'h0;
    else if (valid_i) last_o <= data_i;
  end
endmodule

// ---- tb.sv ----
// testbench: registers, continuous, resonant, rate and one-shot runs
// assumes the mixer model consumes the generator's mixer output
`timescale 1ns/1ns
module tb;
  import hsg_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i, sample_valid_o, rd_d, pv;
  logic [15:0] rdata_o, sample_o, mixer_data_o, m_last, pg, d, q[$];
  logic [15:0] m [7] = '{16'h7FFF, 16'h00FF, 16'h01FF, 16'h00FF,
    16'h07FF, 16'h00FF, 16'h01FF};
  logic [7:0] a;
  logic [7:0] lv [3];
  hsg_req_t bus;
  integer seed = 32'hc1b9bf43;
  integer fails = 0;
  integer check_count = 0;
  integer n, k;
  event pev;
  always #50 clk_i = ~clk_i;
  hsg_generator i_hsg_generator (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .bus_i(bus), .rdata_o(rdata_o), .sample_o(sample_o),
    .sample_valid_o(sample_valid_o), .mixer_data_o(mixer_data_o));
  hsg_mix_model i_hsg_mix_model (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .valid_i(sample_valid_o), .data_i(mixer_data_o), .last_o(m_last));
  task cmp(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] ad, input logic [15:0] wd);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: ad, wdata: wd};
    @(posedge clk_i);
    bus <= '0;
    @(posedge clk_i);
  endtask
  task rd(input logic [7:0] ad, input logic [15:0] e);
    q.push_back(e);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: ad, wdata: 16'h0};
    @(posedge clk_i);
    bus <= '0;
    @(posedge clk_i);
  endtask
  task smp(input logic [15:0] g, input logic [15:0] e);
    pg = g;
    q.push_back(e);
    -> pev;
  endtask
  task finish_test;
    $display("checks %0d errors %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // counts ticks across one half period of the resonant square wave
  task lra_half;
    repeat (2) begin
      d = sample_o;
      do @(negedge clk_i); while (sample_o === d);
    end
    d = sample_o;
    n = 0;
    while (sample_o === d) begin
      n += pv;
      @(negedge clk_i);
    end
    smp(n[15:0], 16'h2C19);
  endtask
  always @(posedge clk_i) rd_d <= bus.rd;
  always @(negedge clk_i) pv <= sample_valid_o;
  always @(negedge clk_i) if (rd_d) cmp(rdata_o, q.pop_front());
  always @(pev) cmp(pg, q.pop_front());
  initial begin
    repeat (100000) @(posedge clk_i);
    fails++;
    finish_test;
  end
  initial begin
    rst_n_i = 1'b0;
    bus = '0;
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    for (a = 8'h90; a < 8'h9B; a++) rd(a, a == 8'h91 ? 16'h7FFF : 16'h0);
    for (a = 8'h91; a < 8'h98; a++) begin
      d = 16'($random(seed));
      wr(a, d);
      rd(a, d & m[a - 8'h91]);
    end
    d = 16'($random(seed));
    wr(8'h90, d);
    rd(8'h90, d & 16'h780E);
    for (k = 0; k < 3; k++) lv[k] = 8'($random(seed)) | 8'h11;
    wr(8'h99, 16'h0006);
    wr(8'h92, {8'h00, lv[0]});
    wr(8'h94, {8'h00, lv[1]});
    wr(8'h96, {8'h00, lv[2]});
    wr(8'h90, 16'h0004);
    repeat (10) @(posedge clk_i);
    smp(m_last, {lv[1], 8'h00});
    wr(8'h91, 16'h2C18);
    wr(8'h90, 16'h0006);
    lra_half;
    for (k = 0; k < 2; k++) begin
      wr(8'h90, k ? 16'h4004 : 16'h0004);
      n = 0;
      repeat (4000) @(negedge clk_i) n += sample_valid_o;
      @(posedge clk_i);
      n = n - (k ? 2258 : 2458);
      smp({15'h0, n >= -1 && n <= 1}, 16'h0001);
    end
    wr(8'h93, 16'h0001);
    wr(8'h95, 16'h0002);
    wr(8'h97, 16'h0001);
    wr(8'h90, 16'h0008);
    wr(8'h90, 16'h0018);
    for (k = 0; k < 5; k++) begin
      repeat (k ? 6248 : 2994) @(posedge clk_i);
      d = k == 0 ? {lv[0], 8'h00} : k < 3 ? {lv[1], 8'h00} : 16'h0;
      smp(m_last, k == 3 ? {lv[2], 8'h00} : d);
      rd(8'h98, {15'h0, k < 4});
    end
    finish_test;
  end
endmodule
bind hsg_generator hsg_checker i_hsg_checker (.clk_i(clk_i),
  .rst_n_i(rst_n_i), .bus_i(bus_i), .rdata_o(rdata_o),
  .sample_o(sample_o), .sample_valid_o(sample_valid_o),
  .mixer_data_o(mixer_data_o));
